// file: rtl/citc_consts.vh
// Constants for the camera trigger and general-purpose I/O block.
// Included by rtl/citc_top.v; holds definitions only.
`ifndef CITC_CONSTS_VH
`define CITC_CONSTS_VH

// Register byte offsets
`define CITC_ADDR_TRIG_CTRL 8'h00
`define CITC_ADDR_FREERUN 8'h04
`define CITC_ADDR_IN_CFG 8'h08
`define CITC_ADDR_IN_DELAY 8'h0c
`define CITC_ADDR_OUT_CFG 8'h10
`define CITC_ADDR_OUT_PULSE 8'h14
`define CITC_ADDR_SOFT_CMD 8'h18
`define CITC_ADDR_FLASH_DLY 8'h1c
`define CITC_ADDR_FLASH_WID 8'h20
`define CITC_ADDR_STATUS 8'h24

// Trigger source encodings
`define CITC_SRC_SOFT 3'h0
`define CITC_SRC_LINE1 3'h1
`define CITC_SRC_LINE2 3'h2
`define CITC_SRC_TIMER 3'h3
`define CITC_SRC_COUNTER 3'h4

// Trigger edge encodings
`define CITC_EDGE_RISE 2'h0
`define CITC_EDGE_FALL 2'h1
`define CITC_EDGE_ANY 2'h2

// Output drive source encodings
`define CITC_OSRC_SOFT 2'h0
`define CITC_OSRC_PULSE_CMD 2'h1
`define CITC_OSRC_PULSE_EXP 2'h2

// Clock and microsecond tick
`define CITC_CLK_HZ 32'h0131_2d00
`define CITC_US_PER_S 32'h000f_4240
`define CITC_CYC_PER_US (`CITC_CLK_HZ / `CITC_US_PER_S)

// Debounce range in microseconds
`define CITC_DEBOUNCE_MAX_US 8'hff

// Reset values
`define CITC_FREERUN_PERIOD_RST 16'h03e8
`define CITC_FREERUN_EXP_RST 16'h0064

`endif

// file: rtl/citc_top.v
// Trigger selection and general-purpose I/O control for an area camera.
// Assumes a classic Wishbone master on the 20 MHz clock and input lines
// already synchronous to clk_i; timer and counter end events are pulses.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "citc_consts.vh"

// Behaviour
// - Latched mode changes output only on command bit
// - Command bit applies latch or fires pulse
// - Flash delay reports last-line exposure start delay
// - Flash width reports optimal flash zone width
// - Trigger disabled: internal timers free-run exposures
// - Trigger enabled: selected source starts exposures
// - Host software command starts an exposure
// - Lines pass debounce, delay, inversion
// - Timer one end event as trigger
// - Counter one end event as trigger
// - Lines 1,2 configurable level, debounce, inversion
// - Debounce rejects short noise transitions
// - Debounce period programmable 0 to 255 us
// - Latch off: output follows static value
// - Edge select: rising, falling or any
// - Output pulse delay and width in us
module citc_top #(
    parameter N_IN = 2,
    parameter N_OUT = 2,
    parameter [31:0] FLASH_DELAY_US = 32'h0000_0000,
    parameter [31:0] FLASH_WIDTH_US = 32'h0000_0000
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [N_IN-1:0] line_in_i,
    input wire timer_one_end_event_i,
    input wire counter_one_end_event_i,
    output wire [N_IN-1:0] input_threshold_level_o,
    output reg [N_OUT-1:0] line_out_o,
    output reg exposure_start_o,
    output reg exposure_active_o
);

    // Software-visible settings
    reg trigger_enable_r;
    reg [2:0] trigger_source_select_r;
    reg [1:0] trigger_edge_select_r;
    reg [15:0] freerun_period_r;
    reg [15:0] freerun_exposure_r;
    reg [N_IN-1:0] input_threshold_level_r;
    reg [N_IN-1:0] line_polarity_invert_r;
    reg [8*N_IN-1:0] input_debounce_period_r;
    reg [8*N_IN-1:0] input_delay_r;
    reg [N_OUT-1:0] output_latch_select_r;
    reg [N_OUT-1:0] output_static_value_r;
    reg [2*N_OUT-1:0] output_drive_source_r;
    reg [15:0] output_pulse_delay_r;
    reg [15:0] output_pulse_width_r;
    reg [N_OUT-1:0] soft_cmd_pulse_r;
    reg soft_trig_r;
    reg [15:0] trig_count_r;

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    wire [N_IN-1:0] line_clean;

    assign input_threshold_level_o = input_threshold_level_r;

    // Microsecond tick from the clock divider
    reg [7:0] us_cnt_r;
    reg us_tick_r;
    localparam [31:0] US_LAST = `CITC_CYC_PER_US - 32'h0000_0001;
    always @(posedge clk_i) begin
        if (rst_i) begin
            us_cnt_r <= 8'h00;
            us_tick_r <= 1'b0;
        end else if (us_cnt_r == US_LAST[7:0]) begin
            us_cnt_r <= 8'h00;
            us_tick_r <= 1'b1;
        end else begin
            us_cnt_r <= us_cnt_r + 8'h01;
            us_tick_r <= 1'b0;
        end
    end

    // Register writes; one-cycle ack for every access
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            trigger_enable_r <= 1'b0;
            trigger_source_select_r <= `CITC_SRC_SOFT;
            trigger_edge_select_r <= `CITC_EDGE_RISE;
            freerun_period_r <= `CITC_FREERUN_PERIOD_RST;
            freerun_exposure_r <= `CITC_FREERUN_EXP_RST;
            input_threshold_level_r <= {N_IN{1'b0}};
            line_polarity_invert_r <= {N_IN{1'b0}};
            input_debounce_period_r <= {8*N_IN{1'b0}};
            input_delay_r <= {8*N_IN{1'b0}};
            output_latch_select_r <= {N_OUT{1'b0}};
            output_static_value_r <= {N_OUT{1'b0}};
            output_drive_source_r <= {2*N_OUT{1'b0}};
            output_pulse_delay_r <= 16'h0000;
            output_pulse_width_r <= 16'h0001;
            soft_cmd_pulse_r <= {N_OUT{1'b0}};
            soft_trig_r <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            soft_cmd_pulse_r <= {N_OUT{1'b0}};
            soft_trig_r <= 1'b0;
            if (wb_wr) begin
                case (wb_adr_i)
                    `CITC_ADDR_TRIG_CTRL: begin
                        trigger_enable_r <= wb_dat_i[0];
                        trigger_source_select_r <= wb_dat_i[6:4];
                        trigger_edge_select_r <= wb_dat_i[9:8];
                        soft_trig_r <= wb_dat_i[16];
                    end
                    `CITC_ADDR_FREERUN: begin
                        freerun_period_r <= wb_dat_i[15:0];
                        freerun_exposure_r <= wb_dat_i[31:16];
                    end
                    `CITC_ADDR_IN_CFG: begin
                        input_threshold_level_r <= wb_dat_i[N_IN-1:0];
                        line_polarity_invert_r <= wb_dat_i[N_IN+7:8];
                        input_debounce_period_r <= wb_dat_i[8*N_IN+15:16];
                    end
                    `CITC_ADDR_IN_DELAY:
                        input_delay_r <= wb_dat_i[8*N_IN-1:0];
                    `CITC_ADDR_OUT_CFG: begin
                        output_latch_select_r <= wb_dat_i[N_OUT-1:0];
                        output_static_value_r <= wb_dat_i[N_OUT+7:8];
                        output_drive_source_r <= wb_dat_i[2*N_OUT+15:16];
                    end
                    `CITC_ADDR_OUT_PULSE: begin
                        output_pulse_delay_r <= wb_dat_i[15:0];
                        output_pulse_width_r <= wb_dat_i[31:16];
                    end
                    `CITC_ADDR_SOFT_CMD: // bit 1 is output 1
                        soft_cmd_pulse_r <= wb_dat_i[N_OUT:1];
                    default: ;
                endcase
            end
        end
    end

    // Zero-extended read words; field placement mirrors the write map
    reg [31:0] rd_in_cfg, rd_in_dly, rd_out_cfg, rd_status;
    always @* begin
        {rd_in_cfg, rd_in_dly, rd_out_cfg, rd_status} = 128'h0;
        rd_in_cfg[N_IN-1:0] = input_threshold_level_r;
        rd_in_cfg[N_IN+7:8] = line_polarity_invert_r;
        rd_in_cfg[8*N_IN+15:16] = input_debounce_period_r;
        rd_in_dly[8*N_IN-1:0] = input_delay_r;
        rd_out_cfg[N_OUT-1:0] = output_latch_select_r;
        rd_out_cfg[N_OUT+7:8] = output_static_value_r;
        rd_out_cfg[2*N_OUT+15:16] = output_drive_source_r;
        rd_status[N_IN-1:0] = line_clean;
        rd_status[N_OUT+7:8] = line_out_o;
        rd_status[31:16] = trig_count_r;
    end

    // Read mux; unmapped addresses read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req) begin
            case (wb_adr_i)
                `CITC_ADDR_TRIG_CTRL:
                    wb_dat_o <= {22'h0, trigger_edge_select_r, 1'b0,
                        trigger_source_select_r, 3'h0, trigger_enable_r};
                `CITC_ADDR_FREERUN:
                    wb_dat_o <= {freerun_exposure_r, freerun_period_r};
                `CITC_ADDR_IN_CFG:
                    wb_dat_o <= rd_in_cfg;
                `CITC_ADDR_IN_DELAY:
                    wb_dat_o <= rd_in_dly;
                `CITC_ADDR_OUT_CFG:
                    wb_dat_o <= rd_out_cfg;
                `CITC_ADDR_OUT_PULSE:
                    wb_dat_o <= {output_pulse_width_r, output_pulse_delay_r};
                `CITC_ADDR_FLASH_DLY:
                    wb_dat_o <= FLASH_DELAY_US;
                `CITC_ADDR_FLASH_WID:
                    wb_dat_o <= FLASH_WIDTH_US;
                `CITC_ADDR_STATUS:
                    wb_dat_o <= rd_status;
                default:
                    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Per-line debounce, delay and inversion
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_in
            reg stable_r;
            reg [7:0] db_cnt_r;
            reg [7:0] dl_cnt_r;
            reg pend_r;
            reg pend_val_r;
            reg out_r;
            wire [7:0] db_per = input_debounce_period_r[8*gi+7:8*gi];
            wire [7:0] dl_per = input_delay_r[8*gi+7:8*gi];
            always @(posedge clk_i) begin
                if (rst_i) begin
                    stable_r <= 1'b0;
                    db_cnt_r <= 8'h00;
                    dl_cnt_r <= 8'h00;
                    pend_r <= 1'b0;
                    pend_val_r <= 1'b0;
                    out_r <= 1'b0;
                end else begin
                    // New level must hold db_per microseconds
                    if (line_in_i[gi] == stable_r) begin
                        db_cnt_r <= 8'h00;
                    end else if (db_cnt_r >= db_per) begin
                        stable_r <= line_in_i[gi];
                        db_cnt_r <= 8'h00;
                        pend_r <= 1'b1;
                        pend_val_r <= line_in_i[gi];
                        dl_cnt_r <= 8'h00;
                    end else if (us_tick_r) begin
                        db_cnt_r <= db_cnt_r + 8'h01;
                    end
                    // Programmable input delay
                    if (pend_r && dl_cnt_r >= dl_per) begin
                        pend_r <= 1'b0;
                        out_r <= pend_val_r;
                    end else if (pend_r && us_tick_r) begin
                        dl_cnt_r <= dl_cnt_r + 8'h01;
                    end
                end
            end
            assign line_clean[gi] = out_r ^ line_polarity_invert_r[gi];
        end
    endgenerate

    // Edge detection on the selected line
    reg [N_IN-1:0] line_prev_r;
    always @(posedge clk_i) begin
        if (rst_i)
            line_prev_r <= {N_IN{1'b0}};
        else
            line_prev_r <= line_clean;
    end

    reg sel_lvl;
    reg sel_prev;
    reg line_edge;
    reg trig_hit;
    always @* begin
        sel_lvl = (trigger_source_select_r == `CITC_SRC_LINE2) ?
            line_clean[1] : line_clean[0];
        sel_prev = (trigger_source_select_r == `CITC_SRC_LINE2) ?
            line_prev_r[1] : line_prev_r[0];
        case (trigger_edge_select_r)
            `CITC_EDGE_RISE: line_edge = sel_lvl & ~sel_prev;
            `CITC_EDGE_FALL: line_edge = ~sel_lvl & sel_prev;
            `CITC_EDGE_ANY: line_edge = sel_lvl ^ sel_prev;
            default: line_edge = 1'b0;
        endcase
        case (trigger_source_select_r)
            `CITC_SRC_SOFT: trig_hit = soft_trig_r;
            `CITC_SRC_LINE1: trig_hit = line_edge;
            `CITC_SRC_LINE2: trig_hit = line_edge;
            `CITC_SRC_TIMER: trig_hit = timer_one_end_event_i;
            `CITC_SRC_COUNTER: trig_hit = counter_one_end_event_i;
            default: trig_hit = 1'b0;
        endcase
    end

    // Free-run timer and exposure strobe generation
    reg [15:0] fr_cnt_r;
    reg [15:0] exp_cnt_r;
    wire fr_fire = ~trigger_enable_r & us_tick_r &
        (fr_cnt_r + 16'h0001 >= freerun_period_r);
    wire start = trigger_enable_r ? trig_hit : fr_fire;
    always @(posedge clk_i) begin
        if (rst_i) begin
            fr_cnt_r <= 16'h0000;
            exp_cnt_r <= 16'h0000;
            exposure_start_o <= 1'b0;
            exposure_active_o <= 1'b0;
            trig_count_r <= 16'h0000;
        end else begin
            exposure_start_o <= start;
            if (trigger_enable_r || fr_fire)
                fr_cnt_r <= 16'h0000;
            else if (us_tick_r)
                fr_cnt_r <= fr_cnt_r + 16'h0001;
            if (start) begin
                exposure_active_o <= 1'b1;
                exp_cnt_r <= 16'h0000;
                trig_count_r <= trig_count_r + 16'h0001;
            end else if (exposure_active_o && us_tick_r) begin
                if (exp_cnt_r + 16'h0001 >= freerun_exposure_r)
                    exposure_active_o <= 1'b0;
                exp_cnt_r <= exp_cnt_r + 16'h0001;
            end
        end
    end

    // Output lines: static, latched, or timed pulse
    genvar go;
    generate
        for (go = 0; go < N_OUT; go = go + 1) begin : g_out
            reg [15:0] p_cnt_r;
            reg [1:0] p_st_r;
            wire [1:0] osrc = output_drive_source_r[2*go+1:2*go];
            wire fire = (osrc == `CITC_OSRC_PULSE_CMD) ?
                soft_cmd_pulse_r[go] :
                (osrc == `CITC_OSRC_PULSE_EXP) ? exposure_start_o : 1'b0;
            always @(posedge clk_i) begin
                if (rst_i) begin
                    p_cnt_r <= 16'h0000;
                    p_st_r <= 2'h0;
                    line_out_o[go] <= 1'b0;
                end else if (osrc == `CITC_OSRC_SOFT) begin
                    p_st_r <= 2'h0;
                    if (!output_latch_select_r[go])
                        line_out_o[go] <= output_static_value_r[go];
                    else if (soft_cmd_pulse_r[go])
                        line_out_o[go] <= output_static_value_r[go];
                end else begin
                    // States: 0 idle, 1 delay, 2 width
                    case (p_st_r)
                        2'h0: begin
                            line_out_o[go] <= 1'b0;
                            if (fire) begin
                                p_st_r <= 2'h1;
                                p_cnt_r <= 16'h0000;
                            end
                        end
                        2'h1: begin
                            if (p_cnt_r >= output_pulse_delay_r) begin
                                p_st_r <= 2'h2;
                                p_cnt_r <= 16'h0000;
                                line_out_o[go] <= 1'b1;
                            end else if (us_tick_r) begin
                                p_cnt_r <= p_cnt_r + 16'h0001;
                            end
                        end
                        2'h2: begin
                            if (p_cnt_r >= output_pulse_width_r) begin
                                p_st_r <= 2'h0;
                                line_out_o[go] <= 1'b0;
                            end else if (us_tick_r) begin
                                p_cnt_r <= p_cnt_r + 16'h0001;
                            end
                        end
                        default: p_st_r <= 2'h0;
                    endcase
                end
            end
        end
    endgenerate

endmodule // citc_top

// file: testbench/citc_top_asserts.sv
// Checker for the trigger and I/O block, bound to citc_top.
// Assumes every write uses sel[0]; shadows what the bus configures.
`timescale 1ns/100ps
`include "citc_consts.vh"
module citc_chk #(
    parameter N_IN = 2,
    parameter N_OUT = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [N_IN-1:0] line_in_i,
    input wire timer_one_end_event_i,
    input wire counter_one_end_event_i,
    input wire [N_IN-1:0] input_threshold_level_o,
    input wire [N_OUT-1:0] line_out_o,
    input wire exposure_start_o,
    input wire exposure_active_o
);
    wire wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    reg [3:0] trig_r;
    reg [1:0] thr_r;
    reg [3:0] ocfg_r;
    reg [2:0] wr_r;
    wire quiet = ~wr & ~|wr_r;
    // Shadow of trigger, input and output-1 settings
    always @(posedge clk_i) begin
        if (rst_i) begin
            trig_r <= 4'h0;
            thr_r <= 2'h0;
            ocfg_r <= 4'h0;
            wr_r <= 3'h0;
        end else begin
            wr_r <= {wr_r[1:0], wr};
            if (wr && wb_adr_i == `CITC_ADDR_TRIG_CTRL)
                trig_r <= {wb_dat_i[6:4], wb_dat_i[0]};
            if (wr && wb_adr_i == `CITC_ADDR_IN_CFG)
                thr_r <= wb_dat_i[1:0];
            if (wr && wb_adr_i == `CITC_ADDR_OUT_CFG)
                ocfg_r <= {wb_dat_i[17:16], wb_dat_i[8], wb_dat_i[0]};
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_once;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack late");
    property p_ack_drop;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack held");
    property p_start_pulse;
        exposure_start_o |=> !exposure_start_o;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start strobe longer than one cycle");
    property p_soft;
        wr && wb_adr_i == `CITC_ADDR_TRIG_CTRL && wb_dat_i[16] && wb_dat_i[0]
            && wb_dat_i[6:4] == `CITC_SRC_SOFT && !exposure_active_o
            |-> ##[1:3] exposure_start_o;
    endproperty
    a_soft: assert property (p_soft) else $error("no start on command");
    property p_timer;
        trig_r == {`CITC_SRC_TIMER, 1'b1} && timer_one_end_event_i
            && !exposure_active_o |-> ##[1:3] exposure_start_o;
    endproperty
    a_timer: assert property (p_timer) else $error("no start on timer");
    property p_counter;
        trig_r == {`CITC_SRC_COUNTER, 1'b1} && counter_one_end_event_i
            && !exposure_active_o |-> ##[1:3] exposure_start_o;
    endproperty
    a_counter: assert property (p_counter)
        else $error("no counter start");
    property p_latch;
        quiet && ocfg_r[0] && ocfg_r[3:2] == `CITC_OSRC_SOFT
            |-> $stable(line_out_o[0]);
    endproperty
    a_latch: assert property (p_latch) else $error("latched pin moved");
    property p_static;
        quiet && !ocfg_r[0] && ocfg_r[3:2] == `CITC_OSRC_SOFT
            |-> line_out_o[0] == ocfg_r[1];
    endproperty
    a_static: assert property (p_static) else $error("pin not static");
    property p_thr;
        quiet |-> input_threshold_level_o == thr_r;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold mismatch");
endmodule // citc_chk

bind citc_top citc_chk #(.N_IN(N_IN), .N_OUT(N_OUT)) u_citc_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .line_in_i(line_in_i), .timer_one_end_event_i(timer_one_end_event_i),
    .counter_one_end_event_i(counter_one_end_event_i),
    .input_threshold_level_o(input_threshold_level_o),
    .line_out_o(line_out_o), .exposure_start_o(exposure_start_o),
    .exposure_active_o(exposure_active_o));

// file: testbench/citc_ext_equip.sv
// Model of the external trigger equipment and the end-event sources.
// Assumes the caller runs its tasks from one process at a time.
`timescale 1ns/100ps
module citc_ext_equip (
    input wire clk_i,
    output reg [1:0] line_in_o,
    output reg timer_end_o,
    output reg counter_end_o
);
    // Lines idle low, events idle
    initial begin
        line_in_o = 2'b00;
        timer_end_o = 1'b0;
        counter_end_o = 1'b0;
    end
    // Set one line and hold it for a number of cycles
    task drive_line(input int idx, input logic lvl, input int n);
        begin
            @(posedge clk_i);
            line_in_o[idx] <= lvl;
            repeat (n - 1) @(posedge clk_i);
        end
    endtask
    // One-cycle end event: 0 timer, 1 counter
    task pulse_event(input int which);
        begin
            @(posedge clk_i);
            if (which == 0) timer_end_o <= 1'b1;
            else counter_end_o <= 1'b1;
            @(posedge clk_i);
            timer_end_o <= 1'b0;
            counter_end_o <= 1'b0;
        end
    endtask
endmodule // citc_ext_equip

// file: testbench/test_camera_io_trigger_control.sv
// Self-checking bench for the trigger and I/O block.
// Drives classic Wishbone; lines and events come from the equipment model.
`timescale 1ns/100ps
`include "citc_consts.vh"
module test_camera_io_trigger_control;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [3:0] sel = 4'h0;
    reg [31:0] dat = 32'h0;
    reg [31:0] rd;
    wire [31:0] rdat;
    wire [1:0] lines, thr, outs;
    wire ack, tmr, cnt, start, active;
    int failures = 0;
    int num_checks = 0;
    int starts = 0;
    int hi_cnt = 0;
    int base, k;
    always #25 clk_i = ~clk_i;
    citc_top #(.FLASH_DELAY_US(32'h0000_0011), .FLASH_WIDTH_US(32'h0000_0022))
    u_citc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .line_in_i(lines),
        .timer_one_end_event_i(tmr), .counter_one_end_event_i(cnt),
        .input_threshold_level_o(thr), .line_out_o(outs),
        .exposure_start_o(start), .exposure_active_o(active));
    citc_ext_equip u_citc_ext_equip (.clk_i(clk_i), .line_in_o(lines),
        .timer_end_o(tmr), .counter_end_o(cnt));
    // Count exposure strobes and high cycles of output 1
    always @(posedge clk_i) begin
        if (start === 1'b1) starts <= starts + 1;
        if (outs[0] === 1'b1) hi_cnt <= hi_cnt + 1;
    end
    task check(input string what, input [31:0] exp, input [31:0] got);
        begin
            num_checks++;
            if (got !== exp) begin
                failures++;
                $display("unexpected %s: expected %h, seen %h",
                    what, exp, got);
            end
        end
    endtask
    // One classic cycle; read data lands in rd
    task wb(input logic w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            sel <= 4'hf;
            @(posedge clk_i);
            while (ack !== 1'b1) @(posedge clk_i);
            rd = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task out_step(input [7:0] a, input [31:0] d, input [1:0] e);
        begin
            wb(1'b1, a, d);
            repeat (3) @(posedge clk_i);
            check("line out", e, outs);
        end
    endtask
    task wait_start;
        begin
            @(posedge clk_i);
            while (start !== 1'b1) @(posedge clk_i);
        end
    endtask
    task results;
        begin
            $display("checks %0d, mismatches %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    // Watchdog against a hang
    initial begin
        repeat (80000) @(posedge clk_i);
        failures++;
        results;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `CITC_ADDR_FREERUN, 0);
        check("freerun", {16'h0064, 16'h03e8}, rd);
        wb(1'b1, `CITC_ADDR_FLASH_DLY, 32'hffff_ffff);
        wb(1'b0, `CITC_ADDR_FLASH_DLY, 0);
        check("flash delay", 32'h0000_0011, rd);
        wb(1'b0, `CITC_ADDR_FLASH_WID, 0);
        check("flash width", 32'h0000_0022, rd);
        wb(1'b0, 8'h40, 0);
        check("unmapped", 0, rd);
        $display("test registers done");
        wb(1'b1, `CITC_ADDR_FREERUN, 32'h0005_0014);
        wait_start;
        wait_start;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (start !== 1'b1);
        check("frame period", 400, k);
        check("exposure on", 1, active);
        repeat (150) @(posedge clk_i);
        check("exposure off", 0, active);
        $display("test free run done");
        wb(1'b1, `CITC_ADDR_TRIG_CTRL, 32'h0000_0001);
        repeat (200) @(posedge clk_i);
        base = starts;
        wb(1'b1, `CITC_ADDR_TRIG_CTRL, 32'h0001_0001);
        repeat (1000) @(posedge clk_i);
        check("soft starts", base + 1, starts);
        for (k = 0; k < 2; k++) begin
            wb(1'b1, `CITC_ADDR_TRIG_CTRL, k ? 32'h41 : 32'h31);
            repeat (150) @(posedge clk_i);
            base = starts;
            u_citc_ext_equip.pulse_event(1 - k);
            repeat (150) @(posedge clk_i);
            u_citc_ext_equip.pulse_event(k);
            repeat (10) @(posedge clk_i);
            check("event starts", base + 1, starts);
        end
        $display("test internal sources done");
        for (k = 0; k < 4; k++) begin
            wb(1'b1, `CITC_ADDR_IN_CFG,
                k == 3 ? 32'h0202_0202 : 32'h0202_0002);
            wb(1'b1, `CITC_ADDR_TRIG_CTRL,
                k == 3 ? 32'h21 : 32'h11 | (k << 8));
            repeat (150) @(posedge clk_i);
            base = starts;
            u_citc_ext_equip.drive_line(k == 3, 1'b1, 200);
            check("after rise", base + (k % 2 == 0), starts);
            u_citc_ext_equip.drive_line(k == 3, 1'b0, 200);
            check("after fall", base + 1 + (k == 2), starts);
        end
        check("threshold", 2'h2, thr);
        wb(1'b1, `CITC_ADDR_TRIG_CTRL, 32'h11);
        base = starts;
        u_citc_ext_equip.drive_line(0, 1'b1, 10);
        u_citc_ext_equip.drive_line(0, 1'b0, 200);
        wb(1'b1, `CITC_ADDR_IN_CFG, 32'h00ff_0000);
        u_citc_ext_equip.drive_line(0, 1'b1, 5000);
        u_citc_ext_equip.drive_line(0, 1'b0, 5200);
        check("glitch starts", base, starts);
        u_citc_ext_equip.drive_line(0, 1'b1, 5400);
        u_citc_ext_equip.drive_line(0, 1'b0, 200);
        check("long pulse starts", base + 1, starts);
        $display("test input lines done");
        out_step(`CITC_ADDR_OUT_CFG, 32'h0000_0100, 2'b01);
        out_step(`CITC_ADDR_OUT_CFG, 32'h0000_0303, 2'b01);
        out_step(`CITC_ADDR_SOFT_CMD, 32'h0000_0004, 2'b11);
        out_step(`CITC_ADDR_OUT_CFG, 32'h0000_0003, 2'b11);
        out_step(`CITC_ADDR_SOFT_CMD, 32'h0000_0002, 2'b10);
        out_step(`CITC_ADDR_SOFT_CMD, 32'h0000_0001, 2'b10);
        wb(1'b1, `CITC_ADDR_OUT_CFG, 32'h0001_0000);
        wb(1'b1, `CITC_ADDR_OUT_PULSE, 32'h0002_0001);
        repeat (5) @(posedge clk_i);
        base = hi_cnt;
        wb(1'b1, `CITC_ADDR_SOFT_CMD, 32'h0000_0002);
        repeat (200) @(posedge clk_i);
        check("pulse width", 40, hi_cnt - base);
        wb(1'b1, `CITC_ADDR_OUT_CFG, 32'h0002_0000);
        base = hi_cnt;
        wb(1'b1, `CITC_ADDR_TRIG_CTRL, 32'h0001_0001);
        repeat (200) @(posedge clk_i);
        check("exposure pulse", 40, hi_cnt - base);
        $display("test outputs done");
        results;
    end
endmodule // test_camera_io_trigger_control
